// ---- logic/dac_ctrl_map.svh ----
// Offsets, field positions, reset values and counts of the DAC control port
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH

// Serial peripheral chip address, seven bits
`define CP_SPI_CHIP_ADDR   7'h10
// I2C address, upper five bits; low two come from the strap pins
`define CP_I2C_ADDR_HI     5'h04
// Direction bit level that means read
`define CP_DIR_READ        1'b1

// Register pointer layout and reset
`define CP_PTR_RESET       8'h01
`define CP_PTR_AUTO_INCREMENT_ENABLE_BIT    7
`define CP_PTR_SEL_MSB     2
`define CP_PTR_SEL_W       3
`define CP_PTR_RSVD        4'h0

// Bits in one control byte
`define CP_BITS_PER_BYTE   4'h8
`define CP_LAST_BIT        3'h7

// Control/hardware select level that means hardware mode
`define CP_SEL_HW          1'b0
// Top three mode pins for double and quad speed
`define CP_HW_DOUBLE       3'h7
`define CP_HW_QUAD         3'h6

// Decode outputs after reset
`define CP_SPEED_RESET     2'h0
`define CP_FMT_RESET       2'h0
`define CP_DEEMPH_RESET    2'h3

`endif

// ---- logic/dac_ctrl_pkg.sv ----
// Types of the DAC control port and hardware mode decode
`default_nettype none
package dac_ctrl_pkg;

  typedef enum logic [1:0] {
    SPEED_SINGLE = 2'h0,
    SPEED_DOUBLE = 2'h1,
    SPEED_QUAD   = 2'h2
  } speed_t;

  typedef enum logic [1:0] {
    FMT_LJ24  = 2'h0,
    FMT_I2S24 = 2'h1,
    FMT_RJ16  = 2'h2,
    FMT_RJ24  = 2'h3
  } fmt_t;

  typedef enum logic [1:0] {
    DEEMPH_32K  = 2'h0,
    DEEMPH_44K1 = 2'h1,
    DEEMPH_48K  = 2'h2,
    DEEMPH_OFF  = 2'h3
  } deemph_t;

  typedef enum logic [6:0] {
    I2C_IDLE  = 7'h01,
    I2C_ADDR  = 7'h02,
    I2C_PTR   = 7'h04,
    I2C_WDATA = 7'h08,
    I2C_ACK   = 7'h10,
    I2C_RDATA = 7'h20,
    I2C_RACK  = 7'h40
  } i2c_state_t;

  // Decoded hardware mode
  typedef struct packed {
    speed_t  speed;
    fmt_t    fmt;
    deemph_t deemph;
  } hw_cfg_t;

  // Serial peripheral frame state, link clock domain, cleared by chip select high
  typedef struct packed {
    logic       ok;
    logic [1:0] idx;
    logic [2:0] cnt;
    logic [6:0] sh;
  } frm_t;

  // Completed byte handed to the system domain
  typedef struct packed {
    logic [7:0] value;
    logic       is_ptr;
    logic       tgl;
  } word_t;

  // All system-domain state
  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_s3;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_s3;
    logic       tgl_s1;
    logic       tgl_s2;
    logic       tgl_s3;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic       spi_mode;
    logic [7:0] ptr;
    i2c_state_t state;
    i2c_state_t nxt;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       nack;
    logic       sda_oe;
    logic       hw_mode;
    logic       illegal;
    hw_cfg_t    cfg;
  } sys_t;

endpackage : dac_ctrl_pkg
`default_nettype wire

// ---- logic/ctrl_reg_file.sv ----
// Small memory holding the internal setting registers, registered read
`timescale 1ns/1ps
`default_nettype none
module ctrl_reg_file #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_b,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("ctrl_reg_file: DEPTH exceeds address range");
  end

  // Contents are not reset; software loads them after reset
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[i_raddr];
    end
  end

  assign o_rdata = rdata_q;

endmodule : ctrl_reg_file
`default_nettype wire

// ---- logic/dac_control_port.sv ----
// DAC control port (serial peripheral and I2C slave) with hardware mode decode
//
// Function
// (R1) Reset stays low until supplies and audio clocks are stable, then released.
// (R2) Control transactions run fully asynchronous to the audio sample clocks.
// (R3) Master keeps control lines static when no transaction is in progress.
// (R4) Device is only a slave and never drives the control clock.
// (R5) First chip-select falling edge after power-up selects serial peripheral protocol.
// (R6) Serial peripheral protocol stays selected until the next reset.
// (R7) Serial peripheral data is sampled on control clock rising edges while selected.
// (R8) Serial peripheral frame starts with chip address 0010000; others are ignored.
// (R9) Eighth serial peripheral bit is the read/write indicator.
// (R10) Next eight serial peripheral bits load the register pointer.
// (R11) Following eight bits of a write go to the selected register.
// (R12) I2C address is 00100 plus the two strap pin levels.
// (R13) I2C address byte bit eight: high reads, low writes.
// (R14) I2C write: first byte loads the pointer, further bytes are data.
// (R15) I2C read returns the selected register right after the address byte.
// (R16) Pointer is 8 bits; select field resets to 001, bits 6..3 read zero.
// (R17) Pointer bit 7 enables auto-increment, reset value zero.
// (R18) With auto-increment on, select field advances after each data byte.
// (R19) Single speed: format pins pick left, I2S, right 16 or right 24.
// (R20) Single speed: de-emphasis pins pick 32k, 44.1k, 48k or off.
// (R21) Top mode pins 111 select double speed, same four formats.
// (R22) Top mode pins 110 select quad speed, same four formats.
// (R23) Control/hardware select low means hardware mode, high means control port.
`include "dac_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_control_port #(
  parameter int NUM_REGS = 8,
  parameter int REG_W    = 8
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_ctrl_serial_clock,
  input  wire logic                   i_ctrl_hw_sel,
  input  wire logic                   i_addr_strap_zero,
  input  wire logic                   i_addr_strap_one,
  input  wire logic                   i_ctrl_serial_data,
  input  wire logic                   i_mode_pin_a,
  input  wire logic                   i_mode_pin_b,
  input  wire logic                   i_mode_pin_c,
  input  wire logic                   i_mode_pin_d,
  input  wire logic                   i_mode_pin_top,
  output logic                        o_ctrl_serial_out,
  output logic                        o_ctrl_serial_oe,
  output logic                        o_spi_mode,
  output logic [7:0]                  o_register_pointer,
  output logic                        o_hw_mode,
  output logic                        o_mode_illegal,
  output dac_ctrl_pkg::speed_t        o_speed,
  output dac_ctrl_pkg::fmt_t          o_format,
  output dac_ctrl_pkg::deemph_t       o_deemph
);

  if (NUM_REGS != (1 << `CP_PTR_SEL_W) || REG_W != 8) begin : g_bad_param
    $error("dac_control_port: register file must be eight registers of eight bits");
  end

  localparam dac_ctrl_pkg::sys_t SYS_RST = '{
    ptr:     `CP_PTR_RESET,
    state:   dac_ctrl_pkg::I2C_IDLE,
    nxt:     dac_ctrl_pkg::I2C_IDLE,
    // Bus lines idle high; a zero here would fake a clock edge after reset
    scl_s1:  1'b1,
    scl_s2:  1'b1,
    scl_s3:  1'b1,
    sda_s1:  1'b1,
    sda_s2:  1'b1,
    sda_s3:  1'b1,
    cfg:     '{speed:  dac_ctrl_pkg::speed_t'(`CP_SPEED_RESET),
               fmt:    dac_ctrl_pkg::fmt_t'(`CP_FMT_RESET),
               deemph: dac_ctrl_pkg::deemph_t'(`CP_DEEMPH_RESET)},
    default: '0
  };

  // ---------------------------------------------------------------
  // Link clock domain: serial peripheral receiver
  // ---------------------------------------------------------------
  dac_ctrl_pkg::frm_t  fq;
  dac_ctrl_pkg::frm_t  fd;
  dac_ctrl_pkg::word_t wq;
  dac_ctrl_pkg::word_t wd;
  logic [7:0]          frm_byte;
  logic                frm_clr;

  // Chip select high ends the frame; the link clock may stop between frames
  assign frm_clr = i_addr_strap_zero | ~i_rst_b;

  always_comb begin
    fd       = fq;
    wd       = wq;
    frm_byte = {fq.sh, i_addr_strap_one};
    fd.sh    = frm_byte[6:0];                               // see (R7)
    fd.cnt   = fq.cnt + 3'h1;
    if (fq.cnt == `CP_LAST_BIT) begin
      unique case (fq.idx)
        2'h0: begin
          // Address check and write direction both required to act
          fd.ok  = (frm_byte[7:1] == `CP_SPI_CHIP_ADDR)    // see (R8)
                   && (frm_byte[0] != `CP_DIR_READ);        // see (R9)
          fd.idx = 2'h1;
        end
        2'h1: begin
          fd.idx = 2'h2;
          if (fq.ok) begin
            wd.value  = frm_byte;                           // see (R10)
            wd.is_ptr = 1'b1;
            wd.tgl    = ~wq.tgl;
          end
        end
        default: begin
          if (fq.ok) begin
            wd.value  = frm_byte;                           // see (R11)
            wd.is_ptr = 1'b0;
            wd.tgl    = ~wq.tgl;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ctrl_serial_clock or posedge frm_clr) begin
    if (frm_clr) begin
      fq <= '0;
    end else begin
      fq <= fd;
    end
  end

  // Held stable between toggles, so the system domain may read it after the sync
  always_ff @(posedge i_ctrl_serial_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wq <= '0;
    end else begin
      wq <= wd;
    end
  end

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------
  dac_ctrl_pkg::sys_t q;
  dac_ctrl_pkg::sys_t d;
  logic               ctrl;
  logic               scl_rise;
  logic               scl_fall;
  logic               bus_start;
  logic               bus_stop;
  logic               we;
  logic [2:0]         waddr;
  logic [7:0]         wdata;
  logic [7:0]         rdata;
  logic [2:0]         top3;

  function automatic logic [7:0] ptr_load(input logic [7:0] b);
    ptr_load = {b[`CP_PTR_AUTO_INCREMENT_ENABLE_BIT], `CP_PTR_RSVD, b[`CP_PTR_SEL_MSB:0]};
  endfunction : ptr_load

  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    logic [2:0] sel;
    sel      = p[`CP_PTR_SEL_MSB:0] + 3'h1;
    ptr_step = p[`CP_PTR_AUTO_INCREMENT_ENABLE_BIT] ? {p[7:3], sel} : p;
  endfunction : ptr_step

  always_comb begin
    d         = q;
    we        = 1'b0;
    waddr     = q.ptr[`CP_PTR_SEL_MSB:0];
    wdata     = q.sh;
    // Synchronisers; the second stage feeds logic, the third stage only edge detection
    d.cs_s1   = i_addr_strap_zero;
    d.cs_s2   = q.cs_s1;
    d.cs_s3   = q.cs_s2;
    d.scl_s1  = i_ctrl_serial_clock;
    d.scl_s2  = q.scl_s1;
    d.scl_s3  = q.scl_s2;
    d.sda_s1  = i_ctrl_serial_data;
    d.sda_s2  = q.sda_s1;
    d.sda_s3  = q.sda_s2;
    d.tgl_s1  = wq.tgl;
    d.tgl_s2  = q.tgl_s1;
    d.tgl_s3  = q.tgl_s2;
    d.pin_s1  = {i_ctrl_hw_sel, i_addr_strap_one, i_mode_pin_top,
                 i_mode_pin_d, i_mode_pin_c, i_mode_pin_b, i_mode_pin_a};
    d.pin_s2  = q.pin_s1;
    ctrl      = (q.pin_s2[6] != `CP_SEL_HW);                // see (R23)
    top3      = q.pin_s2[4:2];
    scl_rise  = q.scl_s2 & ~q.scl_s3;
    scl_fall  = ~q.scl_s2 & q.scl_s3;
    bus_start = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
    bus_stop  = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;

    // Hardware mode decode
    d.hw_mode = ~ctrl;                                      // see (R23)
    if (!ctrl) begin
      d.illegal    = 1'b0;
      d.cfg.fmt    = dac_ctrl_pkg::fmt_t'(q.pin_s2[1:0]);   // see (R19)
      d.cfg.deemph = dac_ctrl_pkg::DEEMPH_OFF;
      if (!q.pin_s2[4]) begin
        d.cfg.speed  = dac_ctrl_pkg::SPEED_SINGLE;
        d.cfg.deemph = dac_ctrl_pkg::deemph_t'(q.pin_s2[3:2]); // see (R20)
      end else if (top3 == `CP_HW_DOUBLE) begin
        d.cfg.speed = dac_ctrl_pkg::SPEED_DOUBLE;           // see (R21)
      end else if (top3 == `CP_HW_QUAD) begin
        d.cfg.speed = dac_ctrl_pkg::SPEED_QUAD;             // see (R22)
      end else begin
        // Undefined pin setting: fall back to single speed and flag it
        d.cfg.speed = dac_ctrl_pkg::SPEED_SINGLE;
        d.illegal   = 1'b1;
      end
    end

    // Protocol select: sticky until reset
    if (ctrl && !q.cs_s2 && q.cs_s3) begin
      d.spi_mode = 1'b1;                                    // see (R5) (R6)
    end

    // Serial peripheral bytes arriving from the link domain
    if (ctrl && q.spi_mode && (q.tgl_s2 != q.tgl_s3)) begin // see (R2)
      if (wq.is_ptr) begin
        d.ptr = ptr_load(wq.value);                         // see (R10) (R16)
      end else begin
        we    = 1'b1;                                       // see (R11)
        wdata = wq.value;
        d.ptr = ptr_step(q.ptr);                            // see (R18)
      end
    end

    // I2C slave; only ever drives the data line low, never the clock
    if (!ctrl || q.spi_mode) begin                          // see (R4)
      d.state  = dac_ctrl_pkg::I2C_IDLE;
      d.sda_oe = 1'b0;
    end else if (bus_start) begin
      d.state  = dac_ctrl_pkg::I2C_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.state  = dac_ctrl_pkg::I2C_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.state)
        dac_ctrl_pkg::I2C_IDLE: begin
          d.sda_oe = 1'b0;
        end
        dac_ctrl_pkg::I2C_ADDR,
        dac_ctrl_pkg::I2C_PTR,
        dac_ctrl_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], q.sda_s2};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `CP_BITS_PER_BYTE) begin
            d.cnt    = 4'h0;
            d.sda_oe = 1'b1;
            d.state  = dac_ctrl_pkg::I2C_ACK;
            d.nxt    = dac_ctrl_pkg::I2C_WDATA;
            if (q.state == dac_ctrl_pkg::I2C_ADDR) begin
              if (q.sh[7:1] == {`CP_I2C_ADDR_HI, q.pin_s2[5], q.cs_s2}) begin // see (R12)
                d.nxt = (q.sh[0] == `CP_DIR_READ) ? dac_ctrl_pkg::I2C_RDATA // see (R13)
                                                  : dac_ctrl_pkg::I2C_PTR;
              end else begin
                // Not our address: stay off the bus until the next start
                d.sda_oe = 1'b0;
                d.state  = dac_ctrl_pkg::I2C_IDLE;
              end
            end else if (q.state == dac_ctrl_pkg::I2C_PTR) begin
              d.ptr = ptr_load(q.sh);                       // see (R14) (R16) (R17)
            end else begin
              we    = 1'b1;                                 // see (R14)
              wdata = q.sh;
              d.ptr = ptr_step(q.ptr);                      // see (R18)
            end
          end
        end
        dac_ctrl_pkg::I2C_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
            d.state  = q.nxt;
            if (q.nxt == dac_ctrl_pkg::I2C_RDATA) begin
              d.sh     = rdata;                             // see (R15)
              d.sda_oe = ~rdata[7];
              d.cnt    = 4'h1;
            end
          end
        end
        dac_ctrl_pkg::I2C_RDATA: begin
          if (scl_fall) begin
            if (q.cnt == `CP_BITS_PER_BYTE) begin
              d.sda_oe = 1'b0;
              d.nack   = 1'b1;
              d.state  = dac_ctrl_pkg::I2C_RACK;
              d.ptr    = ptr_step(q.ptr);                   // see (R18)
            end else begin
              d.sda_oe = ~q.sh[6];
              d.sh     = {q.sh[6:0], 1'b0};
              d.cnt    = q.cnt + 4'h1;
            end
          end
        end
        dac_ctrl_pkg::I2C_RACK: begin
          if (scl_rise) begin
            d.nack = q.sda_s2;
          end else if (scl_fall) begin
            if (!q.nack) begin
              // Master wants another byte
              d.sh     = rdata;                             // see (R15)
              d.sda_oe = ~rdata[7];
              d.cnt    = 4'h1;
              d.state  = dac_ctrl_pkg::I2C_RDATA;
            end else begin
              d.state = dac_ctrl_pkg::I2C_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= SYS_RST;                                         // see (R1)
    end else begin
      q <= d;
    end
  end

  ctrl_reg_file #(
    .DEPTH (NUM_REGS),
    .WIDTH (REG_W),
    .AW    (`CP_PTR_SEL_W)
  ) u_regs (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_we      (we),
    .i_waddr   (waddr),
    .i_wdata   (wdata),
    .i_raddr   (q.ptr[`CP_PTR_SEL_MSB:0]),
    .o_rdata   (rdata)
  );

  // Open-drain data line: the driven level is always low
  assign o_ctrl_serial_out  = 1'b0;
  assign o_ctrl_serial_oe   = q.sda_oe;
  assign o_spi_mode         = q.spi_mode;
  assign o_register_pointer = q.ptr;
  assign o_hw_mode          = q.hw_mode;
  assign o_mode_illegal     = q.illegal;
  assign o_speed            = q.cfg.speed;
  assign o_format           = q.cfg.fmt;
  assign o_deemph           = q.cfg.deemph;

endmodule : dac_control_port
`default_nettype wire

// ---- tb/dac_ctrl_asserts.sv ----
// Port-level checker for the DAC control port and mode decode
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_asserts (
  input wire logic                  i_clk_sys,
  input wire logic                  i_rst_b,
  input wire logic                  i_ctrl_serial_clock,
  input wire logic                  i_ctrl_hw_sel,
  input wire logic                  i_addr_strap_zero,
  input wire logic                  i_mode_pin_a,
  input wire logic                  i_mode_pin_b,
  input wire logic                  i_mode_pin_c,
  input wire logic                  i_mode_pin_d,
  input wire logic                  i_mode_pin_top,
  input wire logic                  o_ctrl_serial_out,
  input wire logic                  o_ctrl_serial_oe,
  input wire logic                  o_spi_mode,
  input wire logic [7:0]            o_register_pointer,
  input wire logic                  o_hw_mode,
  input wire logic                  o_mode_illegal,
  input wire dac_ctrl_pkg::speed_t  o_speed,
  input wire dac_ctrl_pkg::fmt_t    o_format,
  input wire dac_ctrl_pkg::deemph_t o_deemph
);
  logic [4:0] pins;
  assign pins = {i_mode_pin_top, i_mode_pin_d, i_mode_pin_c, i_mode_pin_b, i_mode_pin_a};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  AST_PTR_RSVD: assert property (o_register_pointer[6:3] == 4'h0)
    else $error("pointer reserved bits set");
  AST_SPI_STICKY: assert property (o_spi_mode |=> o_spi_mode)
    else $error("serial peripheral mode dropped");
  AST_SPI_ARM: assert property ($fell(i_addr_strap_zero) && i_ctrl_hw_sel |-> ##[1:6] o_spi_mode)
    else $error("chip select fall did not arm serial peripheral mode");
  AST_NO_OE_SPI: assert property (o_spi_mode |-> !o_ctrl_serial_oe)
    else $error("data line driven in serial peripheral mode");
  AST_OE_SCL_LOW: assert property ($changed(o_ctrl_serial_oe) |-> !i_ctrl_serial_clock)
    else $error("data line changed while clock high");
  AST_OD_LOW: assert property (o_ctrl_serial_out == 1'b0)
    else $error("open-drain level not low");
  AST_HW_SEL: assert property ($stable(i_ctrl_hw_sel) [*4] |-> o_hw_mode == !i_ctrl_hw_sel)
    else $error("hardware mode flag wrong");
  AST_HW_SINGLE: assert property ((!i_ctrl_hw_sel && !pins[4] && $stable(pins)) [*4]
    |-> o_speed == dac_ctrl_pkg::SPEED_SINGLE && o_format == pins[1:0] && o_deemph == pins[3:2])
    else $error("single speed decode wrong");
  AST_HW_DOUBLE: assert property ((!i_ctrl_hw_sel && pins[4:2] == 3'h7 && $stable(pins)) [*4]
    |-> o_speed == dac_ctrl_pkg::SPEED_DOUBLE && o_format == pins[1:0])
    else $error("double speed decode wrong");
  AST_HW_QUAD: assert property ((!i_ctrl_hw_sel && pins[4:2] == 3'h6 && $stable(pins)) [*4]
    |-> o_speed == dac_ctrl_pkg::SPEED_QUAD && o_format == pins[1:0])
    else $error("quad speed decode wrong");
  AST_HW_ILLEGAL: assert property ((!i_ctrl_hw_sel && pins[4:3] == 2'h2 && $stable(pins)) [*4]
    |-> o_mode_illegal && o_deemph == dac_ctrl_pkg::DEEMPH_OFF)
    else $error("undefined mode pins not flagged");
endmodule : dac_ctrl_asserts
bind dac_control_port dac_ctrl_asserts i_chk (.i_clk_sys, .i_rst_b, .i_ctrl_serial_clock,
  .i_ctrl_hw_sel, .i_addr_strap_zero, .i_mode_pin_a, .i_mode_pin_b, .i_mode_pin_c,
  .i_mode_pin_d, .i_mode_pin_top, .o_ctrl_serial_out, .o_ctrl_serial_oe, .o_spi_mode,
  .o_register_pointer, .o_hw_mode, .o_mode_illegal, .o_speed, .o_format, .o_deemph);
`default_nettype wire

// ---- tb/ctrl_master_model.sv ----
// Control bus master model: serial peripheral frames and I2C transfers
`timescale 1ns/1ps
`default_nettype none
module ctrl_master_model (
  output logic      o_scl,
  output logic      o_cs,
  output logic      o_din,
  output logic      o_sda_pull,
  input  wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_cs = 1'b0; // Strap held static low for I2C use
    o_din = 1'b1;
    o_sda_pull = 1'b0;
  end
  // Data moves 30 ns after the clock falls, so the synced clock edge always lands first
  task automatic i2c_bit(input logic b, output logic r);
    o_scl = 1'b0;
    #30 o_sda_pull = !b;
    #95 o_scl = 1'b1;
    #60 r = i_sda;
    #65;
  endtask : i2c_bit
  task automatic i2c_start;
    if (!(o_scl && i_sda)) begin
      o_scl = 1'b0;
      #30 o_sda_pull = 1'b0;
      #95 o_scl = 1'b1;
      #125;
    end
    o_sda_pull = 1'b1;
    #125;
  endtask : i2c_start
  task automatic i2c_stop;
    o_scl = 1'b0;
    #30 o_sda_pull = 1'b1;
    #95 o_scl = 1'b1;
    #125 o_sda_pull = 1'b0;
    #125;
  endtask : i2c_stop
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
    i2c_bit(1'b1, r);
    ack = !r;
  endtask : i2c_byte
  task automatic i2c_read(output logic [7:0] b, input logic m_ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, r);
      b[i] = r;
    end
    i2c_bit(!m_ack, r);
  endtask : i2c_read
  // Link clock runs at 125 ns only inside the frame and idles low
  task automatic spi_frame(input logic [23:0] f);
    o_scl = 1'b0;
    o_cs = 1'b1;
    #300 o_cs = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      #31 o_din = f[i];
      #31.5 o_scl = 1'b1;
      #62.5 o_scl = 1'b0;
    end
    #100 o_din = !o_din;
    o_cs = 1'b1;
    #300;
  endtask : spi_frame
endmodule : ctrl_master_model
`default_nettype wire

// ---- tb/tb_dac_control_port.sv ----
// Self-checking testbench for the DAC control port and mode decode
`timescale 1ns/1ps
`default_nettype none
module tb_dac_control_port;
  logic                  clk, rst_b, sel, scl, cs, din, pull, sda, oe, sout, spi, hw, ill, ack;
  logic [4:0]            pins;
  logic [7:0]            ptr, rd;
  dac_ctrl_pkg::speed_t  spd;
  dac_ctrl_pkg::fmt_t    fmt;
  dac_ctrl_pkg::deemph_t dem;
  int                    errors = 0;
  int                    n_checks = 0;
  assign sda = !(oe | pull);
  dac_control_port i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ctrl_serial_clock(scl),
    .i_ctrl_hw_sel(sel), .i_addr_strap_zero(cs), .i_addr_strap_one(din),
    .i_ctrl_serial_data(sda), .i_mode_pin_a(pins[0]), .i_mode_pin_b(pins[1]),
    .i_mode_pin_c(pins[2]), .i_mode_pin_d(pins[3]), .i_mode_pin_top(pins[4]),
    .o_ctrl_serial_out(sout), .o_ctrl_serial_oe(oe), .o_spi_mode(spi),
    .o_register_pointer(ptr), .o_hw_mode(hw), .o_mode_illegal(ill), .o_speed(spd),
    .o_format(fmt), .o_deemph(dem));
  ctrl_master_model i_mst (.o_scl(scl), .o_cs(cs), .o_din(din), .o_sda_pull(pull),
    .i_sda(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic t_reset;
    chk(ptr, 8'h01, "reset pointer");
    chk(dem, dac_ctrl_pkg::DEEMPH_OFF, "reset deemph");
    chk({spi, oe}, 8'h00, "reset spi/oe");
  endtask : t_reset
  task automatic t_hw;
    logic [1:0] sp, de;
    logic il;
    sel = 1'b0;
    for (int k = 0; k < 32; k++) begin
      @(negedge clk) pins = 5'(k);
      sp = dac_ctrl_pkg::SPEED_SINGLE;
      de = pins[4] ? dac_ctrl_pkg::DEEMPH_OFF : pins[3:2];
      il = pins[4] && !pins[3];
      if (pins[4:2] == 3'h7) sp = dac_ctrl_pkg::SPEED_DOUBLE;
      if (pins[4:2] == 3'h6) sp = dac_ctrl_pkg::SPEED_QUAD;
      repeat (5) @(negedge clk);
      chk(spd, sp, "speed");
      chk(fmt, pins[1:0], "format");
      chk(dem, de, "deemph");
      chk(ill, il, "illegal");
      chk(hw, 1'b1, "hw mode");
    end
  endtask : t_hw
  task automatic t_i2c_write;
    sel = 1'b1;
    repeat (5) @(negedge clk);
    chk(hw, 1'b0, "ctrl mode");
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h20, ack);
    chk(ack, 1'b0, "foreign address acked");
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h24, ack);
    chk(ack, 1'b1, "own address");
    i_mst.i2c_byte(8'hFA, ack);
    i_mst.i2c_byte(8'h5A, ack);
    i_mst.i2c_byte(8'hC3, ack);
    chk(ack, 1'b1, "data ack");
    i_mst.i2c_stop();
    chk(ptr, 8'h84, "pointer after two data bytes");
  endtask : t_i2c_write
  task automatic t_i2c_read;
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h24, ack);
    i_mst.i2c_byte(8'h02, ack);
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h25, ack);
    chk(ack, 1'b1, "read address");
    i_mst.i2c_read(rd, 1'b0);
    i_mst.i2c_stop();
    chk(rd, 8'h5A, "read no auto_increment_enable");
    chk(ptr, 8'h02, "pointer held");
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h24, ack);
    i_mst.i2c_byte(8'h82, ack);
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h25, ack);
    i_mst.i2c_read(rd, 1'b1);
    chk(rd, 8'h5A, "first read");
    i_mst.i2c_read(rd, 1'b0);
    i_mst.i2c_stop();
    chk(rd, 8'hC3, "second read");
    chk(ptr, 8'h84, "pointer after reads");
  endtask : t_i2c_read
  task automatic t_spi;
    chk(spi, 1'b0, "spi before edge");
    i_mst.spi_frame({7'h11, 1'b0, 8'h85, 8'h00});
    chk(spi, 1'b1, "spi armed");
    chk(ptr, 8'h84, "foreign frame");
    i_mst.spi_frame({7'h10, 1'b1, 8'h85, 8'h00});
    chk(ptr, 8'h84, "read frame ignored");
    i_mst.spi_frame({7'h10, 1'b0, 8'h86, 8'h77});
    chk(ptr, 8'h87, "pointer load and step");
    i_mst.i2c_start();
    i_mst.i2c_byte(8'h24, ack);
    i_mst.i2c_stop();
    chk({spi, ack}, 8'h02, "i2c after spi");
  endtask : t_spi
  initial begin
    rst_b = 1'b0;
    sel = 1'b0;
    pins = 5'h00;
    repeat (5) @(negedge clk);
    t_reset();
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_hw();
    t_i2c_write();
    t_i2c_read();
    t_spi();
    give_verdict();
  end
  // Whole run needs well under 100 us
  initial begin
    #500000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_dac_control_port
`default_nettype wire
